// file: hdl/fld_load_postinc.sv
// fld_load_postinc: executes the field load with pointer postincrement.
// assumes the extraction unit returns the field right-justified and acks
// at least one cycle after its request; all inputs synchronous to ref_clk.
//
// Behaviour
// (RL1) Decode the instruction when opcode bits 15..10 are 100101, with bit 9 as select, then pointer, bank and target fields.
// (RL2) After the fetch add the selected field size to the pointer register and write the sum back.
// (RL3) Use the pointer contents as a bit address and fetch a field of 1 to 32 bits of the selected size.
// (RL4) An omitted select operand encodes as 0, so select 0 is the default pair.
// (RL5) Select 0 uses size and extension pair 0, select 1 uses pair 1.
// (RL6) Place the field right-justified and fill the upper bits with its top bit when extension is set, else zeros.
// (RL7) Compare the extended 32-bit value against zero to update the flags.
// (RL8) The negative flag follows bit 31 of the extended value.
// (RL9) The zero flag is set exactly when the extended value is zero.
// (RL10) The carry flag is untouched and the overflow flag is cleared.
// (RL11) The extended field goes into the target general register, not memory.
// (RL12) Pointer and target come from the same bank, chosen by one opcode bit.
// (RL13) The pointer increment wraps at 32 bits and the flags reflect the written value; the code uses the field when a shared register keeps the pointer sum.
`timescale 1ns/1ps

module fld_load_postinc
    import fld_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            clkEn,
    input  wire fld_instr_type   instrIn,
    output logic                 instrReady,
    output logic                 instrDone,
    output logic                 instrIllegal,
    output fld_mem_req_type      memReqOut,
    input  wire fld_mem_rsp_type memRspIn,
    input  wire fld_bus_type     busIn,
    output logic [31:0]          busRdata,
    output logic [3:0]           flagsOut
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // a size code of zero stands for 32 bits
    function automatic logic [5:0] fldSize(input logic [4:0] code);
        fldSize = {(code == 5'h00), code};
    endfunction

    // mask and extend a raw field that arrives right-justified
    function automatic logic [31:0] fldExtend(input logic [31:0] raw,
                                              input logic [5:0]  size,
                                              input logic        ext);
        logic [31:0] mask;
        logic [31:0] res;
        logic        top;
        mask = (size >= 6'h20) ? 32'hFFFF_FFFF
                               : ((32'h0000_0001 << size) - 32'h0000_0001);
        res  = raw & mask;
        top  = raw[5'(size - 6'h01)];
        if (ext && top) begin
            res = res | ~mask;
        end
        fldExtend = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    fld_core_type st_reg;
    fld_core_type st_next;

    logic [31:0]  extValue;
    logic [31:0]  ptrSum;
    logic [4:0]   ptrIdx;
    logic [4:0]   dstIdx;
    logic [4:0]   issuePtrIdx;
    logic         opcMatch;
    logic         issueSel;

    assign ptrIdx      = {st_reg.bank, st_reg.ptrNum};                           // [RL12]
    assign dstIdx      = {st_reg.bank, st_reg.dstNum};                           // [RL12]
    assign issuePtrIdx = {instrIn.opcode[FLD_BANK_BIT],
                          instrIn.opcode[FLD_PTR_LSB +: 4]};                     // [RL12]
    assign opcMatch    = (instrIn.opcode[FLD_OPC_TOP_LSB +: 6] == FLD_OPC_PATTERN); // [RL1]
    assign issueSel    = instrIn.opcode[FLD_SEL_BIT];                            // [RL4]
    assign extValue    = fldExtend(memRspIn.data, st_reg.memSize, st_reg.ext);   // [RL6]
    assign ptrSum      = st_reg.memAddr + {26'h0, st_reg.memSize};               // [RL13]

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next         = st_reg;
        st_next.done    = 1'b0;
        st_next.illegal = 1'b0;
        st_next.memReq  = 1'b0;

        // register port writes; unmapped addresses are ignored
        if (busIn.wr) begin
            if (busIn.addr <= FLD_ADDR_GPR_LAST) begin
                st_next.gprs[busIn.addr[4:0]] = busIn.wdata;
            end else if (busIn.addr == FLD_ADDR_STATUS) begin
                st_next.flags = busIn.wdata[3:0];
            end else if (busIn.addr == FLD_ADDR_CFG) begin
                st_next.cfg = busIn.wdata[11:0];
            end
        end

        // register port reads; unmapped addresses read zero
        if (busIn.rd) begin
            if (busIn.addr <= FLD_ADDR_GPR_LAST) begin
                st_next.rdata = st_reg.gprs[busIn.addr[4:0]];
            end else if (busIn.addr == FLD_ADDR_STATUS) begin
                st_next.rdata = {27'h0, (st_reg.state == FLD_FETCH), st_reg.flags};
            end else if (busIn.addr == FLD_ADDR_CFG) begin
                st_next.rdata = {20'h0, st_reg.cfg};
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end

        case (st_reg.state)
            FLD_IDLE: begin
                if (instrIn.valid) begin
                    if (opcMatch) begin                                          // [RL1]
                        st_next.ptrNum  = instrIn.opcode[FLD_PTR_LSB +: 4];
                        st_next.dstNum  = instrIn.opcode[FLD_RD_LSB +: 4];
                        st_next.bank    = instrIn.opcode[FLD_BANK_BIT];          // [RL12]
                        st_next.memAddr = st_reg.gprs[issuePtrIdx];              // [RL3]
                        if (issueSel) begin                                      // [RL5]
                            st_next.memSize = fldSize(st_reg.cfg[FLD_SIZE1_LSB +: 5]);
                            st_next.ext     = st_reg.cfg[FLD_EXT1_BIT];
                        end else begin                                           // [RL4]
                            st_next.memSize = fldSize(st_reg.cfg[FLD_SIZE0_LSB +: 5]);
                            st_next.ext     = st_reg.cfg[FLD_EXT0_BIT];
                        end
                        st_next.memReq     = 1'b1;                               // [RL3]
                        st_next.instrReady = 1'b0;
                        st_next.state      = FLD_FETCH;
                    end else begin
                        st_next.illegal = 1'b1;
                    end
                end
            end
            FLD_FETCH: begin
                if (memRspIn.ack) begin
                    // target first, pointer last: a shared register keeps the pointer
                    st_next.gprs[dstIdx]      = extValue;                        // [RL11]
                    st_next.gprs[ptrIdx]      = ptrSum;                          // [RL2]
                    st_next.flags[FLD_FLAG_N] = extValue[31];                    // [RL8]
                    st_next.flags[FLD_FLAG_Z] = (extValue == 32'h0000_0000);     // [RL7] [RL9]
                    st_next.flags[FLD_FLAG_V] = 1'b0;                            // [RL10]
                    st_next.done              = 1'b1;
                    st_next.instrReady        = 1'b1;
                    st_next.state             = FLD_IDLE;
                end
            end
            default: begin
                st_next.state      = FLD_IDLE;
                st_next.instrReady = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= FLD_CORE_RST;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign instrReady   = st_reg.instrReady;
    assign instrDone    = st_reg.done;
    assign instrIllegal = st_reg.illegal;
    assign memReqOut    = '{req: st_reg.memReq, bitAddr: st_reg.memAddr,
                            size: st_reg.memSize};
    assign busRdata     = st_reg.rdata;
    assign flagsOut     = st_reg.flags;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_DECODE_MISMATCH: assert property ( // [RL1]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && !opcMatch
        |=> instrIllegal && !memReqOut.req && st_reg.state == FLD_IDLE)
        else $error("non-matching opcode was not refused");

    AST_DECODE_ISSUE: assert property ( // [RL1]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch
        |=> memReqOut.req && !instrReady && st_reg.state == FLD_FETCH)
        else $error("matching opcode did not start a fetch");

    AST_PTR_ADVANCE: assert property ( // [RL2]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack
        |=> st_reg.gprs[ptrIdx] == $past(st_reg.memAddr) + {26'h0, $past(st_reg.memSize)})
        else $error("pointer not advanced by field size");

    AST_FETCH_ADDR: assert property ( // [RL3]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch
        |=> memReqOut.bitAddr == $past(st_reg.gprs[issuePtrIdx])
            && memReqOut.size >= 6'h01 && memReqOut.size <= 6'h20)
        else $error("fetch address or size wrong");

    AST_SEL_ZERO: assert property ( // [RL4]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch && !issueSel
        |=> memReqOut.size == fldSize($past(st_reg.cfg[FLD_SIZE0_LSB +: 5]))
            && st_reg.ext == $past(st_reg.cfg[FLD_EXT0_BIT]))
        else $error("select 0 did not pick pair 0");

    AST_SEL_ONE: assert property ( // [RL5]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch && issueSel
        |=> memReqOut.size == fldSize($past(st_reg.cfg[FLD_SIZE1_LSB +: 5]))
            && st_reg.ext == $past(st_reg.cfg[FLD_EXT1_BIT]))
        else $error("select 1 did not pick pair 1");

    AST_EXTEND: assert property ( // [RL6]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && ptrIdx != dstIdx
        |=> st_reg.gprs[dstIdx]
            == fldExtend($past(memRspIn.data), $past(st_reg.memSize), $past(st_reg.ext)))
        else $error("target value not the extended field");

    AST_NEG_FLAG: assert property ( // [RL8]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && ptrIdx != dstIdx
        |=> flagsOut[FLD_FLAG_N] == st_reg.gprs[dstIdx][31])
        else $error("negative flag disagrees with target");

    AST_ZERO_FLAG: assert property ( // [RL9] [RL7]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && ptrIdx != dstIdx
        |=> flagsOut[FLD_FLAG_Z] == (st_reg.gprs[dstIdx] == 32'h0000_0000))
        else $error("zero flag disagrees with target");

    AST_CV_FLAGS: assert property ( // [RL10]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && !busIn.wr
        |=> flagsOut[FLD_FLAG_C] == $past(flagsOut[FLD_FLAG_C])
            && !flagsOut[FLD_FLAG_V] && instrDone)
        else $error("carry changed or overflow not cleared");

    AST_TARGET_IN_BANK: assert property ( // [RL11] [RL12]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch
        |=> st_reg.bank == $past(instrIn.opcode[FLD_BANK_BIT])
            && st_reg.dstNum == $past(instrIn.opcode[FLD_RD_LSB +: 4]))
        else $error("target not taken from the pointer bank");

    AST_PTR_WRAP: assert property ( // [RL13]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack
        && (&st_reg.memAddr[31:5]) && st_reg.memSize == 6'h20
        |=> st_reg.gprs[ptrIdx] == {27'h0, $past(st_reg.memAddr[4:0])})
        else $error("pointer did not wrap at 32 bits");

    AST_DECODE_FIELDS: assert property ( // [RL1] [RL12]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch
        |=> st_reg.ptrNum == $past(instrIn.opcode[FLD_PTR_LSB +: 4])
            && memReqOut.req)
        else $error("pointer field not taken from the opcode");

    AST_FETCH_HOLD: assert property ( // [RL3]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && !memRspIn.ack
        |=> st_reg.state == FLD_FETCH && !instrReady
            && $stable(memReqOut.bitAddr) && $stable(memReqOut.size))
        else $error("fetch request changed before the field arrived");

    AST_REQ_PULSE: assert property ( // [RL3]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && memReqOut.req |=> !memReqOut.req)
        else $error("fetch request longer than one cycle");

    AST_SIZE_CODE_ZERO: assert property ( // [RL3] [RL5]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_IDLE && instrIn.valid && opcMatch && !issueSel
        && st_reg.cfg[FLD_SIZE0_LSB +: 5] == 5'h00
        |=> memReqOut.size == 6'h20)
        else $error("size code zero did not fetch 32 bits");

    AST_ZERO_EXTEND: assert property ( // [RL6]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && ptrIdx != dstIdx
        && !st_reg.ext && st_reg.memSize == 6'h01
        |=> st_reg.gprs[dstIdx][31:1] == 31'h0)
        else $error("one-bit field not zero extended");

    AST_SIGN_EXTEND: assert property ( // [RL6]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && ptrIdx != dstIdx
        && st_reg.ext && st_reg.memSize == 6'h01
        |=> st_reg.gprs[dstIdx] == {32{$past(memRspIn.data[0])}})
        else $error("one-bit field not sign extended");

    AST_ILLEGAL_QUIET: assert property ( // [RL1]
        @(posedge ref_clk) disable iff (!reset_n)
        instrIllegal |-> instrReady && !memReqOut.req && st_reg.state == FLD_IDLE)
        else $error("refused opcode started a fetch");

    AST_DONE_READY: assert property ( // [RL2]
        @(posedge ref_clk) disable iff (!reset_n)
        instrDone |-> instrReady && !memReqOut.req && st_reg.state == FLD_IDLE)
        else $error("done without returning to idle");

    AST_DONE_PULSE: assert property ( // [RL2]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && instrDone |=> !instrDone)
        else $error("done longer than one cycle");

    AST_OTHER_BANK_KEPT: assert property ( // [RL11] [RL12]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && memRspIn.ack && !busIn.wr
        |=> st_reg.gprs[dstIdx ^ 5'h10] == $past(st_reg.gprs[dstIdx ^ 5'h10]))
        else $error("load touched the other register bank");

    AST_FLAGS_KEPT: assert property ( // [RL7]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && !(st_reg.state == FLD_FETCH && memRspIn.ack) && !busIn.wr
        |=> $stable(flagsOut))
        else $error("flags changed outside a completed load");

    AST_PTR_HELD: assert property ( // [RL2]
        @(posedge ref_clk) disable iff (!reset_n)
        clkEn && st_reg.state == FLD_FETCH && !memRspIn.ack && !busIn.wr
        |=> st_reg.gprs[ptrIdx] == $past(st_reg.gprs[ptrIdx]))
        else $error("pointer moved before the field arrived");

    AST_NZ_EXCLUSIVE: assert property ( // [RL8] [RL9]
        @(posedge ref_clk) disable iff (!reset_n)
        instrDone |-> !(flagsOut[FLD_FLAG_N] && flagsOut[FLD_FLAG_Z]))
        else $error("negative and zero flags both set after a load");

endmodule

// file: pkg/fld_pkg.sv
// fld_pkg: constants, carriers and state type of the field load with
// pointer postincrement execution block.
// assumes one 40 MHz clock domain and a bit-addressed field extraction unit.
package fld_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // opcode layout
    localparam logic [5:0]  FLD_OPC_PATTERN = 6'h25;
    localparam int          FLD_OPC_TOP_LSB = 10;
    localparam int          FLD_SEL_BIT     = 9;
    localparam int          FLD_PTR_LSB     = 5;
    localparam int          FLD_BANK_BIT    = 4;
    localparam int          FLD_RD_LSB      = 0;

    ////////////////////////////////////////////////////////////////////////////
    // register port map (word index)
    localparam logic [5:0]  FLD_ADDR_GPR_LAST = 6'h1F;
    localparam logic [5:0]  FLD_ADDR_STATUS   = 6'h20;
    localparam logic [5:0]  FLD_ADDR_CFG      = 6'h21;

    // status word: NCZV in bits 3..0, busy in bit 4
    localparam int          FLD_FLAG_N   = 3;
    localparam int          FLD_FLAG_C   = 2;
    localparam int          FLD_FLAG_Z   = 1;
    localparam int          FLD_FLAG_V   = 0;
    localparam int          FLD_BUSY_BIT = 4;

    // config word: size/extension pairs
    localparam int          FLD_SIZE0_LSB = 0;
    localparam int          FLD_EXT0_BIT  = 5;
    localparam int          FLD_SIZE1_LSB = 6;
    localparam int          FLD_EXT1_BIT  = 11;

    localparam logic [3:0]  FLD_FLAGS_RST = 4'h0;
    localparam logic [11:0] FLD_CFG_RST   = 12'h000;
    localparam logic [31:0] FLD_GPR_RST   = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        FLD_IDLE  = 2'h1,
        FLD_FETCH = 2'h2
    } fld_state_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] opcode;
    } fld_instr_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } fld_bus_type;

    typedef struct packed {
        logic        req;
        logic [31:0] bitAddr;
        logic [5:0]  size;
    } fld_mem_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] data;
    } fld_mem_rsp_type;

    typedef struct packed {
        fld_state_type     state;
        logic [31:0][31:0] gprs;
        logic [3:0]        flags;
        logic [11:0]       cfg;
        logic [3:0]        ptrNum;
        logic [3:0]        dstNum;
        logic              bank;
        logic              ext;
        logic              memReq;
        logic [31:0]       memAddr;
        logic [5:0]        memSize;
        logic              instrReady;
        logic              done;
        logic              illegal;
        logic [31:0]       rdata;
    } fld_core_type;

    localparam fld_core_type FLD_CORE_RST = '{
        state:      FLD_IDLE,
        gprs:       {32{FLD_GPR_RST}},
        flags:      FLD_FLAGS_RST,
        cfg:        FLD_CFG_RST,
        ptrNum:     4'h0,
        dstNum:     4'h0,
        bank:       1'b0,
        ext:        1'b0,
        memReq:     1'b0,
        memAddr:    32'h0000_0000,
        memSize:    6'h00,
        instrReady: 1'b1,
        done:       1'b0,
        illegal:    1'b0,
        rdata:      32'h0000_0000
    };

endpackage

// file: verification/field_load_postinc_to_reg_bench.sv
// field_load_postinc_to_reg_bench: random and corner field loads, register port checks.
// assumes the register map and timing of the design; 40 MHz clock.
`timescale 1ns/1ps

module field_load_postinc_to_reg_bench
    import fld_pkg::*;
;
    logic            ref_clk;
    logic            reset_n;
    logic            clkEn;
    logic            slow;
    fld_instr_type   instrIn;
    logic            instrReady;
    logic            instrDone;
    logic            instrIllegal;
    fld_mem_req_type memReqOut;
    fld_mem_rsp_type memRspIn;
    fld_bus_type     busIn;
    logic [31:0]     busRdata;
    logic [3:0]      flagsOut;
    logic [31:0]     gpr [32];
    logic [11:0]     cfg;
    logic [3:0]      flg;
    integer          seed;
    int              mismatches;
    int              compares;
    localparam logic [11:0] CORNER [6] = '{12'h001, 12'h800, 12'h03F, 12'h840, 12'h020, 12'h7C0};

    fld_load_postinc DUT (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
        .instrIn(instrIn), .instrReady(instrReady), .instrDone(instrDone),
        .instrIllegal(instrIllegal), .memReqOut(memReqOut), .memRspIn(memRspIn),
        .busIn(busIn), .busRdata(busRdata), .flagsOut(flagsOut));

    fld_mem_model mem (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
        .memReq(memReqOut), .memRsp(memRspIn));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic busWr(input logic [5:0] a, input logic [31:0] d);
        busIn <= '{1'b1, 1'b0, a, d};
        tick;
        busIn.wr <= 1'b0;
        tick;
    endtask

    task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
        busIn <= '{1'b0, 1'b1, a, 32'h0000_0000};
        tick;
        busIn.rd <= 1'b0;
        chkWord(busRdata, exp);
        tick;
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one load, expectation built from the shadow registers
    task automatic runOp(input logic sel, input logic [3:0] p, input logic bk,
                         input logic [3:0] d, input logic slw);
        logic [31:0] ptr;
        logic [31:0] val;
        logic [4:0]  code;
        logic [5:0]  sz;
        int          n;
        ptr  = gpr[{bk, p}];
        code = sel ? cfg[10:6] : cfg[4:0];
        sz   = (code == 5'h00) ? 6'h20 : {1'b0, code};
        for (int i = 0; i < 32; i++) begin
            val[i] = (i < sz) ? mem.bitAt(ptr + i) : ((sel ? cfg[11] : cfg[5]) & val[sz - 1]);
        end
        slow    <= slw;
        instrIn <= '{1'b1, {FLD_OPC_PATTERN, sel, p, bk, d}};
        tick;
        instrIn.valid <= 1'b0;
        chkWord({30'h0, memReqOut.req, instrReady}, 32'h2);
        chkWord(memReqOut.bitAddr, ptr);
        chkWord({26'h0, memReqOut.size}, {26'h0, sz});
        n = 0;
        while (instrDone !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        chkWord({30'h0, instrDone, instrReady}, 32'h3);
        gpr[{bk, d}] = val;
        gpr[{bk, p}] = ptr + {26'h0, sz};
        flg = {val[31], flg[2], val == 32'h0, 1'b0};
        chkWord({28'h0, flagsOut}, {28'h0, flg});
        tick;
        rdChk({1'b0, bk, d}, gpr[{bk, d}]);
        rdChk({1'b0, bk, p}, gpr[{bk, p}]);
        rdChk(6'h20, {28'h0, flg});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        test_done;
    end

    initial begin
        logic [31:0] r;
        logic [31:0] ptrV;
        seed       = 15;
        mismatches = 0;
        compares   = 0;
        reset_n    = 1'b0;
        clkEn      = 1'b1;
        slow       = 1'b0;
        instrIn    = '0;
        busIn      = '0;
        cfg        = 12'h000;
        flg        = 4'h0;
        foreach (gpr[i]) gpr[i] = 32'h0000_0000;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        tick;
        rdChk(6'h05, 32'h0000_0000);
        rdChk(6'h20, 32'h0000_0000);
        rdChk(6'h21, 32'h0000_0000);
        busWr(6'h3F, 32'hFFFF_FFFF);
        rdChk(6'h3F, 32'h0000_0000);
        // wrong top bits must be dropped
        instrIn <= '{1'b1, 16'h9A31};
        tick;
        instrIn.valid <= 1'b0;
        chkWord({30'h0, instrIllegal, memReqOut.req}, 32'h2);
        tick;
        // frozen clock enable: a write must not land
        clkEn <= 1'b0;
        busWr(6'h21, 32'h0000_0FFF);
        clkEn <= 1'b1;
        rdChk(6'h21, 32'h0000_0000);
        for (int k = 0; k < 80; k++) begin
            r    = $random(seed);
            ptrV = (k == 1) ? 32'hFFFF_FFF8 : $random(seed);
            cfg  = (k < 6) ? CORNER[k] : r[11:0];
            busWr(6'h21, {20'h0, cfg});
            busWr({1'b0, r[20], r[15:12]}, ptrV);
            gpr[{r[20], r[15:12]}] = ptrV;
            flg = r[26:23];
            busWr(6'h20, {28'h0, flg});
            runOp((k < 6) ? k[0] : r[21], r[15:12], r[20], r[19:16], r[22]);
        end
        test_done;
    end
endmodule

// file: verification/fld_mem_model.sv
// fld_mem_model: bit-addressed field source behind the extraction port.
// assumes req is a one-cycle pulse; slow adds three wait cycles to the ack.
`timescale 1ns/1ps

module fld_mem_model
    import fld_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            slow,
    input  wire fld_mem_req_type memReq,
    output fld_mem_rsp_type      memRsp
);
    logic [1:0]  waitCnt;
    logic        pending;
    logic [31:0] addr;
    logic [5:0]  size;

    ////////////////////////////////////////////////////////////////////////////
    // memory content as a function of the bit address
    function automatic logic bitAt(input logic [31:0] a);
        return a[1] ^ a[4] ^ a[7] ^ (a[2] & a[9]) ^ a[12] ^ a[31];
    endfunction

    // bits above the field carry junk on purpose
    function automatic logic [31:0] fieldAt(input logic [31:0] a, input logic [5:0] s);
        logic [31:0] f;
        for (int i = 0; i < 32; i++) begin
            f[i] = (i < s) ? bitAt(a + i) : i[0];
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // data toggle every cycle outside the ack
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            memRsp  <= '0;
            pending <= 1'b0;
            waitCnt <= 2'h0;
            addr    <= 32'h0000_0000;
            size    <= 6'h00;
        end else begin
            memRsp.ack  <= 1'b0;
            memRsp.data <= ~memRsp.data;
            if (memReq.req) begin
                addr    <= memReq.bitAddr;
                size    <= memReq.size;
                pending <= 1'b1;
                waitCnt <= slow ? 2'h3 : 2'h0;
            end else if (pending && waitCnt != 2'h0) begin
                waitCnt <= waitCnt - 2'h1;
            end else if (pending) begin
                pending     <= 1'b0;
                memRsp.ack  <= 1'b1;
                memRsp.data <= fieldAt(addr, size);
            end
        end
    end
endmodule
